// ---- hw/pfa_pkg.sv ----
// package: constants and types for the parallel flash access port host controller
package pfa_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam logic [1:0] DENS_16M = 2'h0;
  localparam logic [1:0] DENS_8M  = 2'h1;
  localparam logic [1:0] DENS_4M  = 2'h2;
  localparam logic [1:0] DENS_32M = 2'h3;
  localparam int CLK_PERIOD_NS = 4;
  localparam int SETUP_NS   = 20;
  localparam int STROBE_NS  = 60;
  localparam int HOLD_NS    = 20;
  localparam int RESET_NS   = 100;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_CYC  = (RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  typedef enum logic [5:0] {
    ST_IDLE   = 6'h01,
    ST_RESET  = 6'h02,
    ST_SETUP  = 6'h04,
    ST_STROBE = 6'h08,
    ST_HOLD   = 6'h10,
    ST_DONE   = 6'h20
  } pfa_state_t;
endpackage : pfa_pkg

// ---- hw/pfa_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
module pfa_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  always_comb begin
    next_meta = d;
    next_q    = meta;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= next_meta;
      q    <= next_q;
    end
  end
endmodule : pfa_sync

// ---- hw/pfa_host.sv ----
// host-side controller driving the flash access port pins
`timescale 1ns/10ps
module pfa_host
  import pfa_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              port_enable,
  input  wire logic              bus_released,
  input  wire logic [1:0]        density,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic              req_reset,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rsp_valid,
  output logic [DATA_W-1:0]      rsp_rdata,
  output logic [ADDR_W-1:0]      flash_addr,
  output logic                   flash_addr_oe,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic [DATA_W-1:0]      flash_dq_out,
  output logic                   flash_dq_oe,
  output logic                   flash_cs_n,
  output logic                   flash_cs_n_oe,
  output logic                   flash_rd_n,
  output logic                   flash_rd_n_oe,
  output logic                   flash_wr_n,
  output logic                   flash_wr_n_oe,
  output logic                   flash_reset_n,
  output logic                   flash_reset_n_oe
);
  ////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers
  logic [DATA_W-1:0] dq_sync;
  logic              released_sync;
  pfa_sync #(.W(DATA_W)) u_dq_sync (
    .clk (clk),
    .rst (rst),
    .d   (flash_dq_in),
    .q   (dq_sync)
  );
  pfa_sync #(.W(1)) u_rel_sync (
    .clk (clk),
    .rst (rst),
    .d   (bus_released),
    .q   (released_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // address mask for density
  logic [ADDR_W-1:0] addr_mask;
  always_comb begin
    addr_mask = '1;
    case (density)
      DENS_16M: addr_mask[20]    = 1'b0;
      DENS_8M:  addr_mask[20:19] = 2'h0;
      DENS_4M:  addr_mask[20:18] = 3'h0;
      default:  addr_mask        = '1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // access sequencer
  pfa_state_t        state, next_state;
  logic [CNT_W-1:0]  cnt, next_cnt;
  logic              wr_op, next_wr_op;
  logic [ADDR_W-1:0] next_flash_addr;
  logic [DATA_W-1:0] next_flash_dq_out;
  logic              next_addr_oe, next_dq_oe, next_ctl_oe;
  logic              next_cs_n, next_rd_n, next_wr_n;
  logic              next_reset_n, next_reset_n_oe;
  logic              next_req_ready, next_rsp_valid;
  logic [DATA_W-1:0] next_rsp_rdata;
  logic              can_start;

  // owning the bus without release would fight the internal controller
  assign can_start = port_enable & released_sync;

  always_comb begin
    next_state        = state;
    next_cnt          = cnt;
    next_wr_op        = wr_op;
    next_flash_addr   = flash_addr;
    next_flash_dq_out = flash_dq_out;
    next_addr_oe      = flash_addr_oe;
    next_dq_oe        = flash_dq_oe;
    next_ctl_oe       = flash_cs_n_oe;
    next_cs_n         = flash_cs_n;
    next_rd_n         = flash_rd_n;
    next_wr_n         = flash_wr_n;
    next_reset_n      = flash_reset_n;
    next_reset_n_oe   = flash_reset_n_oe;
    next_req_ready    = 1'b0;
    next_rsp_valid    = 1'b0;
    next_rsp_rdata    = rsp_rdata;
    case (state)
      ST_IDLE: begin
        next_cs_n  = 1'b1;
        next_rd_n  = 1'b1;
        next_wr_n  = 1'b1;
        next_dq_oe = 1'b0;
        next_reset_n_oe = 1'b0;
        next_ctl_oe     = 1'b0;
        next_addr_oe    = 1'b0;
        next_req_ready  = can_start & ~req_valid;
        if (can_start && req_valid && req_ready) begin
          next_ctl_oe     = 1'b1;
          next_addr_oe    = 1'b1;
          next_reset_n_oe = 1'b1;
          next_reset_n    = 1'b1;
          next_req_ready  = 1'b0;
          if (req_reset) begin
            next_reset_n = 1'b0;
            next_cnt     = CNT_W'(RESET_CYC - 1);
            next_state   = ST_RESET;
          end else begin
            next_wr_op      = req_write;
            next_flash_addr = req_addr & addr_mask;
            next_flash_dq_out = req_wdata;
            next_dq_oe      = req_write;
            next_cs_n       = 1'b0;
            next_cnt        = CNT_W'(SETUP_CYC - 1);
            next_state      = ST_SETUP;
          end
        end
      end
      ST_RESET: begin
        if (cnt == '0) begin
          next_reset_n   = 1'b1;
          next_rsp_valid = 1'b1;
          next_state     = ST_DONE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_SETUP: begin
        if (cnt == '0) begin
          next_rd_n  = wr_op;
          next_wr_n  = ~wr_op;
          next_cnt   = CNT_W'(STROBE_CYC - 1);
          next_state = ST_STROBE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_STROBE: begin
        if (cnt == '0) begin
          // read data sampled late; sync delay covered by strobe length
          if (!wr_op) begin
            next_rsp_rdata = dq_sync;
          end
          next_rd_n  = 1'b1;
          next_wr_n  = 1'b1;
          next_cnt   = CNT_W'(HOLD_CYC - 1);
          next_state = ST_HOLD;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_HOLD: begin
        // select and data held past the rising strobe edge
        if (cnt == '0) begin
          next_cs_n      = 1'b1;
          next_dq_oe     = 1'b0;
          next_rsp_valid = 1'b1;
          next_state     = ST_DONE;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_DONE: begin
        // release pins here so a level change of density never meets a driven address
        next_addr_oe    = 1'b0;
        next_ctl_oe     = 1'b0;
        next_reset_n_oe = 1'b0;
        next_state      = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state            <= ST_IDLE;
      cnt              <= '0;
      wr_op            <= 1'b0;
      flash_addr       <= '0;
      flash_dq_out     <= '0;
      flash_addr_oe    <= 1'b0;
      flash_dq_oe      <= 1'b0;
      flash_cs_n_oe    <= 1'b0;
      flash_cs_n       <= 1'b1;
      flash_rd_n       <= 1'b1;
      flash_wr_n       <= 1'b1;
      flash_reset_n    <= 1'b1;
      flash_reset_n_oe <= 1'b0;
      req_ready        <= 1'b0;
      rsp_valid        <= 1'b0;
      rsp_rdata        <= '0;
    end else begin
      state            <= next_state;
      cnt              <= next_cnt;
      wr_op            <= next_wr_op;
      flash_addr       <= next_flash_addr;
      flash_dq_out     <= next_flash_dq_out;
      flash_addr_oe    <= next_addr_oe;
      flash_dq_oe      <= next_dq_oe;
      flash_cs_n_oe    <= next_ctl_oe;
      flash_cs_n       <= next_cs_n;
      flash_rd_n       <= next_rd_n;
      flash_wr_n       <= next_wr_n;
      flash_reset_n    <= next_reset_n;
      flash_reset_n_oe <= next_reset_n_oe;
      req_ready        <= next_req_ready;
      rsp_valid        <= next_rsp_valid;
      rsp_rdata        <= next_rsp_rdata;
    end
  end

  assign flash_rd_n_oe = flash_cs_n_oe;
  assign flash_wr_n_oe = flash_cs_n_oe;
endmodule : pfa_host

// ---- test/pfa_host_asserts.sv ----
// checker: pin framing and timing assertions for the flash host
`timescale 1ns/10ps
module pfa_host_asserts
  import pfa_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst,
  input wire logic              port_enable,
  input wire logic [1:0]        density,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire logic              rsp_valid,
  input wire logic [ADDR_W-1:0] flash_addr,
  input wire logic              flash_addr_oe,
  input wire logic              flash_dq_oe,
  input wire logic              flash_cs_n,
  input wire logic              flash_rd_n,
  input wire logic              flash_wr_n,
  input wire logic              flash_reset_n,
  input wire logic              flash_reset_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_ready_en; req_ready |-> $past(port_enable); endproperty
  a_ready_en: assert property (p_ready_en) else $error("ready without enable");
  property p_take_rsp; req_valid && req_ready |-> ##26 rsp_valid; endproperty
  a_take_rsp: assert property (p_take_rsp) else $error("response late or early");
  property p_no_rd_wr; !(!flash_rd_n && !flash_wr_n); endproperty
  a_no_rd_wr: assert property (p_no_rd_wr) else $error("read and write together");
  property p_wr_drv; !flash_wr_n |-> !flash_cs_n && flash_dq_oe; endproperty
  a_wr_drv: assert property (p_wr_drv) else $error("write without select or data");
  property p_rd_rel; !flash_rd_n |-> !flash_cs_n && !flash_dq_oe; endproperty
  a_rd_rel: assert property (p_rd_rel) else $error("read while driving data");
  property p_wr_pulse;
    $fell(flash_wr_n) |-> ##14 !flash_wr_n ##1 flash_wr_n && !flash_cs_n && flash_dq_oe;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe shape wrong");
  property p_dq_idle; !flash_addr_oe |-> !flash_dq_oe; endproperty
  a_dq_idle: assert property (p_dq_idle) else $error("data driven while idle");
  property p_rst_idle; !flash_addr_oe |-> !flash_reset_n_oe; endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("reset pin driven idle");
  property p_dens;
    flash_addr_oe && density != DENS_32M |-> (flash_addr >> (20 - density)) == '0;
  endproperty
  a_dens: assert property (p_dens) else $error("unused address bit set");
  property p_rst_op; $fell(flash_reset_n) |-> ##25 $rose(flash_reset_n); endproperty
  a_rst_op: assert property (p_rst_op) else $error("flash reset pulse wrong");
  // no write strobe may land while the flash is held in reset
  property p_rst_nowr; !flash_reset_n |-> flash_wr_n && flash_reset_n_oe; endproperty
  a_rst_nowr: assert property (p_rst_nowr) else $error("write during flash reset");
endmodule : pfa_host_asserts
bind pfa_host pfa_host_asserts i_pfa_host_asserts (.*);

// ---- test/pfa_flash_model.sv ----
// behavioural flash die seen through the access port
`timescale 1ns/10ps
module pfa_flash_model
  import pfa_pkg::*;
(
  input  wire logic [1:0]        density,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_host,
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic              reset_n,
  output logic      [DATA_W-1:0] dq_flash
);
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] eff;
  assign eff = (density == DENS_32M) ? addr : addr & (21'h0fffff >> density);
  initial dq_flash = '0;
  always @(posedge wr_n) if (!cs_n && reset_n) mem[eff] = dq_host;
  // released bus inverts its last value on each cs_n, rd_n, reset_n or address change
  always @(cs_n, rd_n, reset_n, eff) begin
    if (!cs_n && !rd_n && reset_n) dq_flash = mem.exists(eff) ? mem[eff] : 16'hffff;
    else dq_flash = ~dq_flash;
  end
endmodule : pfa_flash_model

// ---- test/tb_top.sv ----
// testbench: host controller against the flash model
`timescale 1ns/10ps
module tb_top;
  import pfa_pkg::*;
  logic clk = 0, rst = 1, port_enable = 0, bus_released = 0;
  logic req_valid = 0, req_write = 0, req_reset = 0, req_ready, rsp_valid;
  logic [1:0] density = 2'h3;
  logic [ADDR_W-1:0] req_addr = '0, flash_addr;
  logic [DATA_W-1:0] req_wdata = '0, rsp_rdata, flash_dq_out, dq_flash;
  logic flash_addr_oe, flash_dq_oe, flash_cs_n, flash_cs_n_oe, flash_rd_n, flash_rd_n_oe;
  logic flash_wr_n, flash_wr_n_oe, flash_reset_n, flash_reset_n_oe;
  logic [DATA_W-1:0] exp_mem [logic [ADDR_W-1:0]];
  int n_fail = 0, cmp_count = 0;
  wire [DATA_W-1:0] flash_dq_in = flash_dq_oe ? flash_dq_out : dq_flash;
  pfa_host i_pfa_host (.*);
  pfa_flash_model i_pfa_flash_model (.density(density), .addr(flash_addr),
    .dq_host(flash_dq_in), .cs_n(flash_cs_n_oe ? flash_cs_n : 1'b1),
    .rd_n(flash_rd_n_oe ? flash_rd_n : 1'b1), .wr_n(flash_wr_n_oe ? flash_wr_n : 1'b1),
    .reset_n(flash_reset_n_oe ? flash_reset_n : 1'b1), .dq_flash(dq_flash));
  always #2 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [ADDR_W-1:0] eff_addr(input logic [1:0] d, input logic [20:0] a);
    return (d == 2'h3) ? a : a & (21'h0fffff >> d);
  endfunction : eff_addr
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic op(input logic w, input logic r, input logic [20:0] a, input logic [15:0] d);
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 100) begin @(posedge clk); k++; end
    req_valid <= 1; req_write <= w; req_reset <= r; req_addr <= a; req_wdata <= d;
    @(posedge clk);
    req_valid <= 0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 60) begin @(posedge clk); k++; end
    check({15'h0, rsp_valid}, 16'h1);
    if (w && !r) exp_mem[eff_addr(density, a)] = d;
    if (!w && !r) check(rsp_rdata, exp_mem.exists(eff_addr(density, a)) ?
      exp_mem[eff_addr(density, a)] : 16'hffff);
  endtask : op
  task automatic wrap_up;
    $display("fails=%0d compares=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
  initial begin
    logic [20:0] a;
    logic [15:0] d;
    void'($urandom(32'h31fe));
    repeat (6) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 3; i++) begin
      {port_enable, bus_released} <= i[1:0];
      repeat (10) @(posedge clk);
      check({15'h0, req_ready}, 16'h0);
    end
    port_enable <= 1; bus_released <= 1;
    for (int dn = 0; dn < 4; dn++) begin
      density <= dn[1:0];
      for (int n = 0; n < 5; n++) begin
        a = (n == 0) ? 21'h1fffff : 21'($urandom);
        d = (n == 0) ? 16'h0000 : 16'($urandom);
        op(1, 0, a, d);
        op(0, 0, a ^ 21'h1c0000, 16'h0);
        op(0, 0, a, 16'h0);
      end
    end
    op(0, 1, 21'($urandom), 16'h0);
    op(0, 0, 21'h1fffff, 16'h0);
    wrap_up();
  end
endmodule : tb_top
